// >>> uwd_regwin.sv
// register window decode for one serial channel
`timescale 1ns/1ps
// What this block does
// - each channel answers in its own block of eight byte offsets from io or memory space.
// - with the divisor latch bit set, offsets 0 and 1 select the divisor low and high bytes.
// - one line format byte sets the format of both transmitter and receiver.
// - writing the unused format value opens the enhanced register view.
// - that special write sets only bit 7 and keeps the lower seven format bits.
// - additional control bit 7 maps the extended register set into the window.
// - additional control bit 6 allows read access to the indexed control set; indexed writes pass without it.
// - with the latch bit clear, offset 0 write loads transmit, read returns received data.
// - offset 7 is a scratch byte that also holds the index, read always and written only outside the enhanced view.
// - divisor low at offset 0 holds divisor bits 7 to 0, read/write under the latch bit.
// - divisor high at offset 1 holds divisor bits 15 to 8, read/write under the latch bit.
// - indexed registers are reached through the indexed data port using the scratch index.
module uwd_regwin
  import uwd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic sel_i,
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_ninth_i,
  input wire logic nine_bit_i,
  input wire logic [7:0] int_source_i,
  input wire logic [7:0] line_cond_i,
  input wire logic [7:0] modem_cond_i,
  input wire logic [7:0] ext_rdata_i,
  input wire logic [7:0] idx_rdata_i,
  output logic [7:0] rdata_o,
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic tx_ninth_o,
  output logic rx_take_o,
  output logic queue_wr_o,
  output logic [7:0] queue_data_o,
  output logic [15:0] divisor_o,
  output logic [1:0] data_len_o,
  output logic stop_bits_o,
  output logic parity_en_o,
  output logic parity_even_o,
  output logic parity_force_o,
  output logic tx_break_o,
  output logic [7:0] interrupt_enable_o,
  output logic [7:0] modem_line_control_o,
  output logic enh_view_o,
  output logic ext_map_o,
  output logic idx_open_o,
  output logic ext_wr_o,
  output logic ext_rd_o,
  output logic idx_wr_o,
  output logic idx_rd_o,
  output logic [7:0] index_o
);

  ////////////////////////////////////////////////////////////////
  logic [7:0] line_format;
  logic [7:0] divisor_low;
  logic [7:0] divisor_high;
  logic [7:0] interrupt_enable;
  logic [7:0] modem_line_control;
  logic [7:0] scratch_and_index;
  logic [7:0] additional_control;
  logic enh_view;

  // decode
  // the special format value keeps the latch bit set, so offsets 0 and 1 stay on the divisor
  wire dlab = line_format[FMT_DLAB_BIT];
  wire ext_map = additional_control[ACR_EXT_BIT];
  wire idx_open = additional_control[ACR_IDX_BIT];
  wire wr_hit = sel_i & wr_i;
  wire rd_hit = sel_i & rd_i;
  wire at_data = addr_i == OFS_DATA;
  wire at_ien = addr_i == OFS_IEN;
  wire at_scr = addr_i == OFS_SCRATCH;
  wire wr_dll = wr_hit & at_data & dlab;
  wire wr_dlm = wr_hit & at_ien & dlab;
  wire wr_thr = wr_hit & at_data & ~dlab;
  wire wr_ien = wr_hit & at_ien & ~dlab;
  wire wr_fmt = wr_hit & (addr_i == OFS_FMT);
  wire wr_queue = wr_hit & (addr_i == OFS_QUEUE) & ~enh_view;
  wire wr_mlc = wr_hit & (addr_i == OFS_MLC) & ~enh_view;
  wire wr_scr = wr_hit & at_scr & ~enh_view;
  wire fmt_special = wdata_i == FMT_SPECIAL;
  wire [7:0] next_line_format = fmt_special ? {1'b1, line_format[FMT_DLAB_BIT-1:0]} :
    wdata_i;
  // indexed data port sits at the line status offset 5 in the normal view
  wire idx_port = (addr_i == OFS_LCOND) & ~enh_view & ~dlab;
  wire wr_idx = wr_hit & idx_port;
  wire rd_idx = rd_hit & idx_port & idx_open;
  wire acr_sel = scratch_and_index == ICR_ACR_IDX;
  wire wr_acr = wr_idx & acr_sel;
  wire ext_rd_sel = ext_map & ~dlab & ~enh_view & (addr_i == OFS_IEN | addr_i == OFS_FMT
    | addr_i == OFS_MLC);
  wire ext_wr_sel = ext_map & ~dlab & ~enh_view & at_ien;
  // nine-bit mode swaps the ninth received bit into the line status byte
  logic [7:0] lcond_view;
  always_comb begin
    lcond_view = line_cond_i;
    if (nine_bit_i) begin
      lcond_view[LCOND_NINTH_BIT] = rx_ninth_i;
    end
  end

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = RST_BYTE;
    if (rd_hit) begin
      if (ext_rd_sel) begin
        next_rdata = ext_rdata_i;
      end else if (rd_idx) begin
        next_rdata = acr_sel ? additional_control : idx_rdata_i;
      end else begin
        unique case (addr_i)
          OFS_DATA: next_rdata = dlab ? divisor_low : rx_char_i;
          OFS_IEN: next_rdata = dlab ? divisor_high : interrupt_enable;
          OFS_QUEUE: next_rdata = int_source_i;
          OFS_FMT: next_rdata = line_format;
          OFS_MLC: next_rdata = modem_line_control;
          OFS_LCOND: next_rdata = lcond_view;
          OFS_MCOND: next_rdata = modem_cond_i;
          OFS_SCRATCH: next_rdata = scratch_and_index;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      line_format <= RST_BYTE;
      enh_view <= 1'b0;
    end else if (wr_fmt) begin
      line_format <= next_line_format;
      enh_view <= fmt_special;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      divisor_low <= RST_BYTE;
      divisor_high <= RST_BYTE;
    end else begin
      if (wr_dll) divisor_low <= wdata_i;
      if (wr_dlm) divisor_high <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      interrupt_enable <= RST_BYTE;
      modem_line_control <= RST_BYTE;
      scratch_and_index <= RST_BYTE;
      additional_control <= RST_BYTE;
    end else begin
      if (wr_ien & ~ext_wr_sel) interrupt_enable <= wdata_i;
      if (wr_mlc) modem_line_control <= wdata_i;
      if (wr_scr) scratch_and_index <= wdata_i;
      if (wr_acr) additional_control <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= RST_BYTE;
      tx_load_o <= 1'b0;
      tx_data_o <= RST_BYTE;
      tx_ninth_o <= 1'b0;
      rx_take_o <= 1'b0;
      queue_wr_o <= 1'b0;
      queue_data_o <= RST_BYTE;
      ext_wr_o <= 1'b0;
      ext_rd_o <= 1'b0;
      idx_wr_o <= 1'b0;
      idx_rd_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      tx_load_o <= wr_thr;
      tx_data_o <= wr_thr ? wdata_i : tx_data_o;
      tx_ninth_o <= wr_thr ? scratch_and_index[SCR_NINTH_BIT] & nine_bit_i : tx_ninth_o;
      rx_take_o <= rd_hit & at_data & ~dlab & ~ext_rd_sel;
      queue_wr_o <= wr_queue;
      queue_data_o <= wr_queue ? wdata_i : queue_data_o;
      ext_wr_o <= wr_hit & ext_wr_sel;
      ext_rd_o <= rd_hit & ext_rd_sel;
      idx_wr_o <= wr_idx & ~acr_sel;
      idx_rd_o <= rd_idx & ~acr_sel;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      divisor_o <= {RST_BYTE, RST_BYTE};
      data_len_o <= 2'h0;
      stop_bits_o <= 1'b0;
      parity_en_o <= 1'b0;
      parity_even_o <= 1'b0;
      parity_force_o <= 1'b0;
      tx_break_o <= 1'b0;
      interrupt_enable_o <= RST_BYTE;
      modem_line_control_o <= RST_BYTE;
      enh_view_o <= 1'b0;
      ext_map_o <= 1'b0;
      idx_open_o <= 1'b0;
      index_o <= RST_BYTE;
    end else begin
      divisor_o <= {divisor_high, divisor_low};
      data_len_o <= line_format[FMT_LEN_W-1:0];
      stop_bits_o <= line_format[FMT_STOP_BIT];
      parity_en_o <= line_format[FMT_PAR_EN_BIT];
      parity_even_o <= line_format[FMT_PAR_EVEN_BIT];
      parity_force_o <= line_format[FMT_PAR_FORCE_BIT];
      tx_break_o <= line_format[FMT_BREAK_BIT];
      interrupt_enable_o <= interrupt_enable;
      modem_line_control_o <= modem_line_control;
      enh_view_o <= enh_view;
      ext_map_o <= ext_map;
      idx_open_o <= idx_open;
      index_o <= scratch_and_index;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  special_keeps_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_fmt && fmt_special |=> line_format == {1'b1, $past(line_format[FMT_DLAB_BIT-1:0])})
    else $error("special format write altered low bits");
  special_opens_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_fmt && fmt_special |=> ##1 enh_view_o)
    else $error("enhanced view not opened");
  view_exit_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_fmt && !fmt_special |=> !enh_view && line_format == $past(wdata_i))
    else $error("enhanced view not closed");
  dll_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && at_data && dlab |=> divisor_low == $past(wdata_i) ##1
    divisor_o[7:0] == $past(wdata_i, 2))
    else $error("divisor low not written");
  dlm_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && at_ien && dlab |=> divisor_high == $past(wdata_i))
    else $error("divisor high not written");
  dlm_no_ien_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && at_ien && dlab |=> interrupt_enable == $past(interrupt_enable))
    else $error("interrupt enable written under latch bit");
  tx_load_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && at_data && !dlab |=> tx_load_o && tx_data_o == $past(wdata_i))
    else $error("transmit load missing");
  dll_no_tx_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && dlab |=> !tx_load_o)
    else $error("transmit loaded under latch bit");
  rx_read_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_hit && at_data && !dlab && !ext_rd_sel |=> rdata_o == $past(rx_char_i))
    else $error("received char not returned");
  dll_no_take_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_hit && at_data && dlab |=> !rx_take_o)
    else $error("divisor read consumed a character");
  rdata_idle_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !rd_hit |=> rdata_o == RST_BYTE)
    else $error("read data without read");
  scratch_rw_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_scr ##1 (rd_hit && at_scr && !wr_scr && !ext_rd_sel) |=>
    rdata_o == $past(wdata_i, 2))
    else $error("scratch readback wrong");
  scratch_refused_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && at_scr && enh_view |=> scratch_and_index == $past(scratch_and_index))
    else $error("scratch written in enhanced view");
  ext_map_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_hit && ext_rd_sel |=> ext_rd_o && rdata_o == $past(ext_rdata_i))
    else $error("extended read not routed");
  ext_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_hit && ext_wr_sel |=> ext_wr_o && interrupt_enable == $past(interrupt_enable))
    else $error("extended write not routed");
  idx_gate_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !idx_open |=> !idx_rd_o)
    else $error("indexed read while closed");
  acr_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_acr |=> additional_control == $past(wdata_i))
    else $error("additional control not written");
  idx_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_idx && !acr_sel |=> idx_wr_o)
    else $error("indexed write not passed on");
  ninth_rx_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_hit && addr_i == OFS_LCOND && !ext_rd_sel && !rd_idx && nine_bit_i |=>
    rdata_o[LCOND_NINTH_BIT] == $past(rx_ninth_i))
    else $error("ninth rx bit missing");
  ninth_tx_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_thr && nine_bit_i |=> tx_ninth_o == $past(scratch_and_index[SCR_NINTH_BIT]))
    else $error("ninth tx bit not taken from scratch");
  fmt_out_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    1'b1 |=> {tx_break_o, parity_force_o, parity_even_o, parity_en_o, stop_bits_o,
    data_len_o} == $past(line_format[FMT_DLAB_BIT-1:0]))
    else $error("format outputs stale");
  sel_gate_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !sel_i |=> !tx_load_o && !ext_wr_o && !idx_wr_o)
    else $error("action without select");

  enh_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i) wr_fmt && fmt_special);
  dll_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i) wr_dll);
  idx_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i) idx_rd_o);
  ext_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i) ext_rd_o);
  b2b_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i) wr_scr ##1 rd_hit);

endmodule // uwd_regwin

// >>> uwd_pkg.sv
// constants for the serial channel register window decode
package uwd_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_QUEUE = 3'h2;
  localparam logic [2:0] OFS_FMT = 3'h3;
  localparam logic [2:0] OFS_MLC = 3'h4;
  localparam logic [2:0] OFS_LCOND = 3'h5;
  localparam logic [2:0] OFS_MCOND = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  localparam logic [7:0] FMT_SPECIAL = 8'hbf;
  localparam int FMT_DLAB_BIT = 7;
  localparam int FMT_LEN_W = 2;
  localparam int FMT_STOP_BIT = 2;
  localparam int FMT_PAR_EN_BIT = 3;
  localparam int FMT_PAR_EVEN_BIT = 4;
  localparam int FMT_PAR_FORCE_BIT = 5;
  localparam int FMT_BREAK_BIT = 6;
  localparam int ACR_EXT_BIT = 7;
  localparam int ACR_IDX_BIT = 6;
  localparam int LCOND_NINTH_BIT = 2;
  localparam int SCR_NINTH_BIT = 0;
  localparam logic [7:0] ICR_ACR_IDX = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_LCOND = 8'h60;
endpackage : uwd_pkg

// >>> tb_top.sv
// self-checking testbench for the serial channel register window decode
`timescale 1ns/1ps
module tb_top;
  import uwd_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sel_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rx_ninth_i = 1'b0;
  logic nine_bit_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rx_char_i = 8'h5a;
  logic [7:0] int_source_i = 8'hc1;
  logic [7:0] line_cond_i = RST_LCOND;
  logic [7:0] modem_cond_i = 8'h3c;
  logic [7:0] ext_rdata_i = 8'h9e;
  logic [7:0] idx_rdata_i = 8'h47;
  logic [7:0] rdata_o, tx_data_o, queue_data_o, interrupt_enable_o, modem_line_control_o, index_o;
  logic [15:0] divisor_o;
  logic [1:0] data_len_o;
  logic tx_load_o, tx_ninth_o, rx_take_o, queue_wr_o, stop_bits_o, parity_en_o, parity_even_o;
  logic parity_force_o, tx_break_o, enh_view_o, ext_map_o, idx_open_o;
  logic ext_wr_o, ext_rd_o, idx_wr_o, idx_rd_o;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  uwd_regwin i_uwd_regwin (.mclk_i(mclk_i), .srst_i(srst_i), .sel_i(sel_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rx_char_i(rx_char_i), .rx_ninth_i(rx_ninth_i),
    .nine_bit_i(nine_bit_i), .int_source_i(int_source_i), .line_cond_i(line_cond_i),
    .modem_cond_i(modem_cond_i), .ext_rdata_i(ext_rdata_i), .idx_rdata_i(idx_rdata_i),
    .rdata_o(rdata_o), .tx_load_o(tx_load_o), .tx_data_o(tx_data_o), .tx_ninth_o(tx_ninth_o),
    .rx_take_o(rx_take_o), .queue_wr_o(queue_wr_o), .queue_data_o(queue_data_o),
    .divisor_o(divisor_o), .data_len_o(data_len_o), .stop_bits_o(stop_bits_o),
    .parity_en_o(parity_en_o), .parity_even_o(parity_even_o), .parity_force_o(parity_force_o),
    .tx_break_o(tx_break_o), .interrupt_enable_o(interrupt_enable_o),
    .modem_line_control_o(modem_line_control_o), .enh_view_o(enh_view_o),
    .ext_map_o(ext_map_o), .idx_open_o(idx_open_o), .ext_wr_o(ext_wr_o), .ext_rd_o(ext_rd_o),
    .idx_wr_o(idx_wr_o), .idx_rd_o(idx_rd_o), .index_o(index_o));

  initial forever #25 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one access; returns just after the taking edge, while pulses and rdata stand
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] wd);
    @(posedge mclk_i);
    sel_i <= 1'b1;
    wr_i <= w;
    rd_i <= ~w;
    addr_i <= a;
    wdata_i <= wd;
    @(posedge mclk_i);
    sel_i <= 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    addr_i <= ~a;
    wdata_i <= ~wd;
    #1;
  endtask

  // write then read at one offset on consecutive edges
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] wd);
    @(posedge mclk_i);
    sel_i <= 1'b1;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= wd;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    sel_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
  endtask

  // config levels trail the write by one more cycle
  task automatic settle();
    @(posedge mclk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    #1;
    chk("rst_divisor", divisor_o, 16'h0000);
    chk("rst_flags", 16'({enh_view_o, ext_map_o, idx_open_o, index_o}), 16'h0000);
    acc(1'b1, OFS_DATA, 8'h96);
    chk("tx_load", 16'({tx_load_o, tx_data_o}), 16'h0196);
    acc(1'b0, OFS_DATA, 8'h00);
    chk("rx_read", 16'({rx_take_o, rdata_o}), 16'h015a);
    acc(1'b1, OFS_QUEUE, 8'h07);
    chk("queue_wr", 16'({queue_wr_o, queue_data_o}), 16'h0107);
    acc(1'b1, OFS_IEN, 8'h0f);
    acc(1'b1, OFS_MLC, 8'h13);
    settle();
    chk("ien_mlc", {interrupt_enable_o, modem_line_control_o}, 16'h0f13);
    acc(1'b0, OFS_QUEUE, 8'h00);
    chk("isr_read", 16'(rdata_o), 16'(int_source_i));
    acc(1'b0, OFS_MCOND, 8'h00);
    chk("msr_read", 16'(rdata_o), 16'(modem_cond_i));
    $display("test access done");
    acc(1'b1, OFS_FMT, 8'h83);
    acc(1'b1, OFS_DATA, 8'h34);
    chk("no_tx_load", 16'(tx_load_o), 16'h0000);
    acc(1'b1, OFS_IEN, 8'h12);
    settle();
    chk("divisor", divisor_o, 16'h1234);
    chk("ien_kept", 16'(interrupt_enable_o), 16'h000f);
    acc(1'b0, OFS_DATA, 8'h00);
    chk("dll_read", 16'(rdata_o), 16'h0034);
    acc(1'b0, OFS_IEN, 8'h00);
    chk("dlm_read", 16'(rdata_o), 16'h0012);
    $display("test divisor done");
    acc(1'b1, OFS_FMT, 8'h7a);
    settle();
    chk("fmt_fields", 16'({data_len_o, stop_bits_o, parity_en_o, parity_even_o, parity_force_o,
      tx_break_o, enh_view_o}), 16'h009e);
    acc(1'b1, OFS_FMT, FMT_SPECIAL);
    settle();
    chk("fmt_special", 16'({data_len_o, stop_bits_o, parity_en_o, parity_even_o, parity_force_o,
      tx_break_o, enh_view_o}), 16'h009f);
    acc(1'b0, OFS_FMT, 8'h00);
    chk("fmt_read", 16'(rdata_o), 16'h00fa);
    acc(1'b1, OFS_SCRATCH, 8'hee);
    acc(1'b1, OFS_FMT, 8'h03);
    settle();
    chk("fmt_exit", 16'({data_len_o, enh_view_o}), 16'h0006);
    acc(1'b0, OFS_SCRATCH, 8'h00);
    chk("scr_refused", 16'(rdata_o), 16'h0000);
    $display("test format done");
    acc(1'b1, OFS_SCRATCH, 8'ha5);
    settle();
    chk("index", 16'(index_o), 16'h00a5);
    acc(1'b0, OFS_SCRATCH, 8'h00);
    chk("scr_read", 16'(rdata_o), 16'h00a5);
    wr_rd(OFS_SCRATCH, 8'hc3);
    chk("scr_b2b", 16'(rdata_o), 16'h00c3);
    @(posedge mclk_i);
    nine_bit_i <= 1'b1;
    rx_ninth_i <= 1'b1;
    acc(1'b0, OFS_LCOND, 8'h00);
    chk("ninth_rx", 16'(rdata_o), 16'h0064);
    acc(1'b1, OFS_DATA, 8'h11);
    chk("ninth_tx", 16'({tx_load_o, tx_ninth_o}), 16'h0003);
    @(posedge mclk_i);
    nine_bit_i <= 1'b0;
    $display("test scratch done");
    acc(1'b1, OFS_SCRATCH, ICR_ACR_IDX);
    acc(1'b1, OFS_LCOND, 8'hc0);
    settle();
    chk("acr_open", 16'({ext_map_o, idx_open_o}), 16'h0003);
    acc(1'b0, OFS_LCOND, 8'h00);
    chk("acr_read", 16'({idx_rd_o, rdata_o}), 16'h00c0);
    acc(1'b1, OFS_SCRATCH, 8'h03);
    acc(1'b0, OFS_LCOND, 8'h00);
    chk("idx_read", 16'({idx_rd_o, rdata_o}), 16'h0147);
    acc(1'b0, OFS_IEN, 8'h00);
    chk("ext_read", 16'({ext_rd_o, rdata_o}), 16'h019e);
    acc(1'b1, OFS_SCRATCH, 8'h03);
    acc(1'b1, OFS_LCOND, 8'h11);
    chk("idx_write", 16'(idx_wr_o), 16'h0001);
    acc(1'b1, OFS_IEN, 8'h22);
    chk("ext_write", 16'(ext_wr_o), 16'h0001);
    acc(1'b1, OFS_SCRATCH, ICR_ACR_IDX);
    acc(1'b1, OFS_LCOND, 8'h00);
    settle();
    chk("acr_closed", 16'({ext_map_o, idx_open_o}), 16'h0000);
    acc(1'b0, OFS_LCOND, 8'h00);
    chk("lsr_back", 16'({idx_rd_o, rdata_o}), 16'h0060);
    $display("test extended done");
    stop_test();
  end
endmodule // tb_top
